//--- logic/cic_irq_ctrl.v
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "cic_defs.vh"
module cic_irq_ctrl #(
  parameter CMD_VALID_MASK = 16'hffff
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [5:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       tx_last_bit_done,
  input  wire       rx_stream_end,
  input  wire       receive_requires_bytes,
  input  wire       fifo_not_empty,
  input  wire       cmd_self_done,
  input  wire       fifo_high_level_status,
  input  wire       fifo_low_level_status,
  input  wire [7:0] error_status,
  input  wire       timer_zero,
  input  wire       secure_signal_input,
  input  wire       mode_detected,
  input  wire       crc_done,
  input  wire       rf_field_present,
  output reg  [3:0] command_code,
  output reg        irq_status,
  output reg        irq_out,
  output reg        irq_oe
);

  reg  [7:0] link_en_q;
  reg  [7:0] aux_en_q;
  reg  [6:0] link_req_q;
  reg  [6:0] link_req_d;
  reg  [4:0] aux_req_q;
  reg  [4:0] aux_req_d;
  reg  [3:0] cmd_q;
  reg  [3:0] cmd_d;
  reg        high_prev_q;
  reg        low_prev_q;
  reg        secure_signal_input_prev_q;
  reg        rf_prev_q;
  reg  [6:0] link_evt;
  reg  [4:0] aux_evt;
  reg        idle_evt;
  reg        status_d;
  reg        pin_level_d;
  reg        pin_enable_d;
  reg  [6:0] aux_apply;
  reg        rx_qualified;
  reg  [7:0] rdata_d;
  reg        sel_cmd;
  reg        sel_link_en;
  reg        sel_aux_en;
  reg        sel_link_req;
  reg        sel_aux_req;
  reg        wr_cmd;
  reg        wr_link_en;
  reg        wr_aux_en;
  reg        wr_link_req;
  reg        wr_aux_req;

  // register select, one target per address; unmapped addresses select nothing
  always @*
  begin
    sel_cmd      = 1'b0;
    sel_link_en  = 1'b0;
    sel_aux_en   = 1'b0;
    sel_link_req = 1'b0;
    sel_aux_req  = 1'b0;
    if (reg_addr == `CIC_OFS_CMD)
    begin
      sel_cmd = 1'b1;
    end
    else if (reg_addr == `CIC_OFS_LINK_EN)
    begin
      sel_link_en = 1'b1;
    end
    else if (reg_addr == `CIC_OFS_AUX_EN)
    begin
      sel_aux_en = 1'b1;
    end
    else if (reg_addr == `CIC_OFS_LINK_REQ)
    begin
      sel_link_req = 1'b1;
    end
    else if (reg_addr == `CIC_OFS_AUX_REQ)
    begin
      sel_aux_req = 1'b1;
    end
  end

  // write strobes per register
  always @*
  begin
    wr_cmd      = reg_wr && sel_cmd;
    wr_link_en  = reg_wr && sel_link_en;
    wr_aux_en   = reg_wr && sel_aux_en;
    wr_link_req = reg_wr && sel_link_req;
    wr_aux_req  = reg_wr && sel_aux_req;
  end

  // apply a set/clear write to a flag vector, hardware events win over a clear
  function [6:0] cic_apply;
    input [6:0] cur;
    input [6:0] evt;
    input       wr;
    input [7:0] data;
    begin
      cic_apply = cur;
      if (wr && data[`CIC_BIT_SET_CLEAR])
        cic_apply = cur | data[6:0];
      else if (wr)
        cic_apply = cur & ~data[6:0];
      cic_apply = cic_apply | evt;
    end
  endfunction

  // pin level for a given status and polarity bit
  function cic_pin_level;
    input status;
    input invert;
    begin
      cic_pin_level = status ^ invert;
    end
  endfunction

  // open drain only drives a low level, push-pull always drives
  function cic_pin_enable;
    input level;
    input push_pull;
    begin
      if (push_pull)
        cic_pin_enable = 1'b1;
      else
        cic_pin_enable = !level;
    end
  endfunction

  // command field and idle event
  // a host write in the same cycle as a self-finish wins, so no stale idle flag
  always @*
  begin
    cmd_d    = cmd_q;
    idle_evt = 1'b0;
    if (wr_cmd)
    begin
      if (!CMD_VALID_MASK[reg_wdata[3:0]])
      begin
        cmd_d    = `CIC_CMD_IDLE;
        idle_evt = 1'b1;
      end
      else
      begin
        cmd_d = reg_wdata[3:0]; // host idle write raises nothing
      end
    end
    else if (cmd_self_done && (cmd_q != `CIC_CMD_IDLE))
    begin
      cmd_d    = `CIC_CMD_IDLE;
      idle_evt = 1'b1;
    end
  end

  // receive end only counts when the byte requirement is met
  always @*
  begin
    rx_qualified = rx_stream_end;
    if (receive_requires_bytes && !fifo_not_empty)
      rx_qualified = 1'b0;
  end

  // link event detection; the FIFO high and low level sources are edge detected so a held level sets once
  always @*
  begin
    link_evt                 = 7'h00;
    link_evt[`CIC_BIT_TX]    = tx_last_bit_done;
    link_evt[`CIC_BIT_RX]    = rx_qualified;
    link_evt[`CIC_BIT_IDLE]  = idle_evt;
    link_evt[`CIC_BIT_HIGH]  = fifo_high_level_status && !high_prev_q;
    link_evt[`CIC_BIT_LOW]   = fifo_low_level_status && !low_prev_q;
    link_evt[`CIC_BIT_FAULT] = |error_status;
    link_evt[`CIC_BIT_TIMER] = timer_zero;
  end

  // aux event detection
  // the field history register makes on and off mutually exclusive in any cycle
  always @*
  begin
    aux_evt                  = 5'h00;
    aux_evt[`CIC_BIT_SECURE_SIGNAL_INPUT]  = secure_signal_input ^ secure_signal_input_prev_q;
    aux_evt[`CIC_BIT_MODE]   = mode_detected;
    aux_evt[`CIC_BIT_CRC]    = crc_done;
    aux_evt[`CIC_BIT_RF_ON]  = rf_field_present && !rf_prev_q;
    aux_evt[`CIC_BIT_RF_OFF] = !rf_field_present && rf_prev_q;
  end

  // next link request flags; software owns clearing, reads never clear
  always @*
  begin
    link_req_d = cic_apply(link_req_q, link_evt, wr_link_req, reg_wdata);
  end

  // next aux request flags; reserved bits are masked out of the write
  always @*
  begin
    aux_apply = cic_apply({2'b00, aux_req_q}, {2'b00, aux_evt}, wr_aux_req,
                          {reg_wdata[7], 2'b00, reg_wdata[4:0]});
    aux_req_d = aux_apply[4:0];
  end

  // internal status from enabled flags of both request registers
  always @*
  begin
    status_d = (|(link_req_d & link_en_q[6:0]))
               | (|(aux_req_d & aux_en_q[4:0]));
  end

  // next pin level and drive enable
  always @*
  begin
    pin_level_d  = cic_pin_level(status_d, link_en_q[`CIC_BIT_INVERT]);
    pin_enable_d = cic_pin_enable(pin_level_d, aux_en_q[`CIC_BIT_DRIVE]);
  end

  // enable registers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      link_en_q <= `CIC_RST_LINK_EN;
      aux_en_q  <= `CIC_RST_AUX_EN;
    end
    else
    begin
      if (wr_link_en)
      begin
        link_en_q <= reg_wdata;
      end
      if (wr_aux_en)
      begin
        aux_en_q <= {reg_wdata[7], 2'b00, reg_wdata[4:0]}; // reserved bits stay zero
      end
    end
  end

  // request registers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      link_req_q <= `CIC_RST_LINK_REQ;
      aux_req_q  <= `CIC_RST_AUX_REQ;
    end
    else
    begin
      link_req_q <= link_req_d;
      aux_req_q  <= aux_req_d;
    end
  end

  // command register
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmd_q <= `CIC_RST_CMD;
    end
    else
    begin
      cmd_q <= cmd_d;
    end
  end

  // input history for the edge detectors
  // cleared at reset, so a source already high at release counts as one edge
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      high_prev_q  <= 1'b0;
      low_prev_q   <= 1'b0;
      secure_signal_input_prev_q <= 1'b0;
      rf_prev_q    <= 1'b0;
    end
    else
    begin
      high_prev_q  <= fifo_high_level_status;
      low_prev_q   <= fifo_low_level_status;
      secure_signal_input_prev_q <= secure_signal_input;
      rf_prev_q    <= rf_field_present;
    end
  end

  // registered status and command outputs
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_status   <= 1'b0;
      command_code <= `CIC_RST_CMD;
    end
    else
    begin
      irq_status   <= status_d;
      command_code <= cmd_d;
    end
  end

  // registered pin outputs; released at reset until software reconfigures
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_out <= 1'b1;
      irq_oe  <= 1'b0;
    end
    else
    begin
      irq_out <= pin_level_d;
      irq_oe  <= pin_enable_d;
    end
  end

  // read data selection; select bits and reserved bits read as zero
  always @*
  begin
    rdata_d = 8'h00;
    if (sel_cmd)
    begin
      rdata_d = {4'h0, cmd_q};
    end
    else if (sel_link_en)
    begin
      rdata_d = link_en_q;
    end
    else if (sel_aux_en)
    begin
      rdata_d = aux_en_q;
    end
    else if (sel_link_req)
    begin
      rdata_d = {1'b0, link_req_q};
    end
    else if (sel_aux_req)
    begin
      rdata_d = {3'b000, aux_req_q};
    end
  end

  // read data, one cycle after the strobe, zero in every other cycle
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

//--- shared/cic_defs.vh
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH
// register offsets
`define CIC_OFS_LINK_EN   6'h02
`define CIC_OFS_AUX_EN    6'h03
`define CIC_OFS_LINK_REQ  6'h04
`define CIC_OFS_AUX_REQ   6'h05
`define CIC_OFS_CMD       6'h01
// reset values
`define CIC_RST_LINK_EN   8'h80
`define CIC_RST_AUX_EN    8'h00
`define CIC_RST_LINK_REQ  7'h14
`define CIC_RST_AUX_REQ   5'h00
`define CIC_RST_CMD       4'h0
// field positions
`define CIC_BIT_SET_CLEAR 7
`define CIC_BIT_INVERT    7
`define CIC_BIT_DRIVE     7
`define CIC_BIT_TX        6
`define CIC_BIT_RX        5
`define CIC_BIT_IDLE      4
`define CIC_BIT_HIGH      3
`define CIC_BIT_LOW       2
`define CIC_BIT_FAULT     1
`define CIC_BIT_TIMER     0
`define CIC_BIT_SECURE_SIGNAL_INPUT     4
`define CIC_BIT_MODE      3
`define CIC_BIT_CRC       2
`define CIC_BIT_RF_ON     1
`define CIC_BIT_RF_OFF    0
// idle command code
`define CIC_CMD_IDLE      4'h0
`endif

//--- sim/cic_host_pin.sv
`timescale 1ns/10ps
module cic_host_pin (
  input  wire irq_out,
  input  wire irq_oe,
  output wire pin
);
  // board pull-up holds the line high while the device lets go
  assign pin = irq_oe ? irq_out : 1'b1;
endmodule

//--- sim/cic_irq_checker.sv
`timescale 1ns/10ps
module cic_irq_checker (
  input wire       clk_sys,
  input wire       rst,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       tx_last_bit_done,
  input wire       irq_status,
  input wire       irq_out,
  input wire       irq_oe
);
  reg [7:0] en_q;
  reg       pp_q;
  // shadows of the enable and drive bits as the host writes them
  always @(posedge clk_sys)
    en_q <= rst ? 8'h80 : (reg_wr && reg_addr == 6'h02) ? reg_wdata : en_q;
  always @(posedge clk_sys)
    pp_q <= rst ? 1'b0 : (reg_wr && reg_addr == 6'h03) ? reg_wdata[7] : pp_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rel; $fell(rst) |-> irq_out && !irq_oe; endproperty
  property p_od; !pp_q ##1 irq_oe |-> !irq_out; endproperty
  property p_pp; pp_q |=> irq_oe; endproperty
  property p_pol; irq_out == (irq_status ^ $past(en_q[7])); endproperty
  property p_tx; tx_last_bit_done && en_q[6] && !reg_wr |=> irq_status; endproperty
  property p_rd7; reg_rd && reg_addr == 6'h04 |=> !reg_rdata[7]; endproperty
  property p_rdq; !reg_rd |=> reg_rdata == 8'h00; endproperty
  property p_unm; reg_rd && reg_addr > 6'h05 |=> reg_rdata == 8'h00; endproperty
  a_rel: assert property (p_rel) else $error("pin not released");
  a_od: assert property (p_od) else $error("open drain drove high");
  a_pp: assert property (p_pp) else $error("push pull not driving");
  a_pol: assert property (p_pol) else $error("pin polarity wrong");
  a_tx: assert property (p_tx) else $error("transmit event lost");
  a_rd7: assert property (p_rd7) else $error("select bit read back");
  a_rdq: assert property (p_rdq) else $error("read data outside window");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_tx: cover property (tx_last_bit_done && en_q[6]);
  c_pp: cover property (pp_q && irq_oe);
  c_rd: cover property (reg_rd && reg_addr == 6'h05);
endmodule
bind cic_irq_ctrl cic_irq_checker u_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_last_bit_done(tx_last_bit_done), .irq_status(irq_status), .irq_out(irq_out),
  .irq_oe(irq_oe));

//--- sim/tb_contactless_irq_controller.sv
`timescale 1ns/10ps
module tb_contactless_irq_controller;
  reg        clk_sys = 1'b0;
  reg        rst = 1'b1;
  reg  [5:0] adr = 6'h00;
  reg  [7:0] wd = 8'h00;
  reg        wr_s = 1'b0;
  reg        rd_s = 1'b0;
  reg  [6:0] lk = 7'h00;
  reg  [4:0] ax = 5'h00;
  reg        need_b = 1'b0;
  reg        fifo_ne = 1'b0;
  reg        sd = 1'b0;
  wire [7:0] rdata;
  wire [3:0] cmd;
  wire       irq_st;
  wire       irq_out;
  wire       irq_oe;
  wire       pin;
  integer    n_fail = 0;
  integer    comparisons = 0;
  integer    i;
  // code 0xf is left unknown
  cic_irq_ctrl #(.CMD_VALID_MASK(16'h7fff)) dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
    .tx_last_bit_done(lk[6]), .rx_stream_end(lk[5]), .receive_requires_bytes(need_b),
    .fifo_not_empty(fifo_ne), .cmd_self_done(sd), .fifo_high_level_status(lk[3]),
    .fifo_low_level_status(lk[2]), .error_status({7'h00, lk[1]}), .timer_zero(lk[0]),
    .secure_signal_input(ax[4]), .mode_detected(ax[3]), .crc_done(ax[2]),
    .rf_field_present(ax[1]), .command_code(cmd), .irq_status(irq_st),
    .irq_out(irq_out), .irq_oe(irq_oe));
  cic_host_pin host (.irq_out(irq_out), .irq_oe(irq_oe), .pin(pin));
  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;
  task chk(input [7:0] got, input [7:0] e);
  begin
    comparisons = comparisons + 1;
    if (got !== e)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, e);
    end
  end
  endtask
  // wait one edge so the registered pin outputs follow the last access
  task chk_pin(input [2:0] e);
  begin
    @(posedge clk_sys);
    #1;
    chk({5'h00, irq_out, irq_oe, pin}, {5'h00, e});
  end
  endtask
  task wr(input [5:0] a, input [7:0] d);
  begin
    adr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys);
    wr_s <= 1'b0;
    #1;
  end
  endtask
  task rd(input [5:0] a, input [7:0] e);
  begin
    adr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  end
  endtask
  // one-cycle event pulse, flags land at the first edge
  task pulse(input [6:0] l, input [4:0] a, input s);
  begin
    lk <= l;
    ax <= a;
    sd <= s;
    @(posedge clk_sys);
    lk <= 7'h00;
    ax <= 5'h00;
    sd <= 1'b0;
    @(posedge clk_sys);
    #1;
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // watchdog far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #40000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  // test sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(6'h02, 8'h80);
    rd(6'h03, 8'h00);
    rd(6'h04, 8'h14);
    chk_pin(3'h5);
    $display("test reset done");
    wr(6'h02, 8'h10);
    chk_pin(3'h5);
    wr(6'h02, 8'h90);
    chk_pin(3'h2);
    wr(6'h04, 8'h7f);
    rd(6'h04, 8'h00);
    chk_pin(3'h5);
    wr(6'h04, 8'h81);
    rd(6'h04, 8'h01);
    $display("test set_clear done");
    wr(6'h02, 8'h7f);
    for (i = 0; i < 7; i = i + 1)
      if (i != 4)
      begin
        pulse(7'h01 << i, 5'h00, 1'b0);
        rd(6'h04, 8'h01 << i);
        chk({7'h00, irq_st}, 8'h01);
        wr(6'h04, 8'h01 << i);
      end
    need_b <= 1'b1;
    pulse(7'h20, 5'h00, 1'b0);
    rd(6'h04, 8'h00);
    fifo_ne <= 1'b1;
    pulse(7'h20, 5'h00, 1'b0);
    rd(6'h04, 8'h20);
    wr(6'h04, 8'h20);
    $display("test link_events done");
    wr(6'h01, 8'h03);
    wr(6'h01, 8'h00);
    rd(6'h04, 8'h00);
    wr(6'h01, 8'h03);
    pulse(7'h00, 5'h00, 1'b1);
    chk({4'h0, cmd}, 8'h00);
    rd(6'h04, 8'h10);
    wr(6'h04, 8'h10);
    wr(6'h01, 8'h03);
    wr(6'h01, 8'h0f);
    chk({4'h0, cmd}, 8'h00);
    rd(6'h04, 8'h10);
    wr(6'h04, 8'h10);
    $display("test commands done");
    wr(6'h03, 8'hff);
    rd(6'h03, 8'h9f);
    for (i = 2; i < 5; i = i + 1)
    begin
      pulse(7'h00, 5'h01 << i, 1'b0);
      rd(6'h05, 8'h01 << i);
      wr(6'h05, 8'h01 << i);
    end
    pulse(7'h00, 5'h02, 1'b0);
    rd(6'h05, 8'h03);
    chk_pin(3'h7);
    wr(6'h05, 8'h03);
    wr(6'h05, 8'h84);
    rd(6'h05, 8'h04);
    wr(6'h3f, 8'hff);
    rd(6'h3f, 8'h00);
    $display("test aux done");
    report_and_stop;
  end
endmodule
